/* File: rtl/tws_top.sv */
// Two-wire synchronous serial channel with AHB-Lite register access
`default_nettype none
module tws_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [tws_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic timer2_tick,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  input wire logic bus_line_a_in,
  output logic bus_line_a_out,
  output logic bus_line_a_oe,
  input wire logic bus_line_b_in,
  output logic bus_line_b_out,
  output logic bus_line_b_oe
);
  import tws_pkg::*;

  logic wr_en;
  logic [IDX_W-1:0] reg_idx;
  logic [7:0] wr_data, rd_data;
  logic div_tick;

  logic [7:0] clk_sel_q, clk_sel_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] bctl_q, bctl_d;
  logic [7:0] interrupt_timing_reg_q, interrupt_timing_reg_d;
  logic [7:0] sva_q, sva_d;
  logic [7:0] sr_q, sr_d;
  logic port_q, port_d;
  logic done_q, done_d;
  tws_state_t state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic sck_lvl_q, sck_lvl_d;
  logic out_latch_q, out_latch_d;
  logic sck_prev_q;
  logic sck_oe_q, sck_oe_d;
  logic a_oe_q, a_oe_d;
  logic b_oe_q, b_oe_d;
  logic sck_out_q, a_out_q, b_out_q;

  logic enable, two_wire, use_line_a, internal_clk, half_tick;
  logic line_in, fall_ev, rise_ev, busy, clock_idle, start, match;
  logic [1:0] src;

  tws_ahb u_ahb (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .wr_en(wr_en),
    .reg_idx(reg_idx),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );

  tws_clkdiv #(
    .CNT_W(DIV_CNT_W)
  ) u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(busy && src == SRC_DIVIDER),
    .code(clk_sel_q[CLKSEL_CH0_LSB +: CLKSEL_CH0_W]),
    .tick(div_tick)
  );

  assign serial_clock_pin_out = sck_out_q;
  assign serial_clock_pin_oe = sck_oe_q;
  assign bus_line_a_out = a_out_q;
  assign bus_line_a_oe = a_oe_q;
  assign bus_line_b_out = b_out_q;
  assign bus_line_b_oe = b_oe_q;

  // Mode decode and serial clock events
  always_comb begin
    enable = mode_q[MODE_EN_BIT];
    two_wire = mode_q[MODE_SEL_HI:MODE_SEL_MID] == MODE_TWO_WIRE;
    use_line_a = mode_q[MODE_SEL_LO];
    src = mode_q[MODE_SRC_HI:MODE_SRC_LO];
    internal_clk = src[1]; // R22
    half_tick = (src == SRC_DIVIDER) ? div_tick : timer2_tick; // R22
    line_in = use_line_a ? bus_line_a_in : bus_line_b_in;
    busy = state_q != ST_IDLE;
    if (internal_clk) begin
      fall_ev = half_tick && sck_lvl_q;
      rise_ev = half_tick && !sck_lvl_q;
      clock_idle = !busy; // R9
    end else begin
      fall_ev = sck_prev_q && !serial_clock_pin_in;
      rise_ev = !sck_prev_q && serial_clock_pin_in;
      clock_idle = !busy && serial_clock_pin_in; // R9
    end
    match = enable && (sva_q == sr_q); // R13 R23
    start = wr_en && reg_idx == IDX_SHIFT && enable && clock_idle; // R9 R10
  end

  // Register read mux
  always_comb begin
    rd_data = 8'h00;
    unique case (reg_idx)
      IDX_CLK_SEL: rd_data = clk_sel_q;
      IDX_MODE: begin
        rd_data = mode_q;
        rd_data[MODE_MATCH_BIT] = match; // R13
      end
      IDX_BUS_CTL: rd_data = bctl_q;
      IDX_SHIFT: rd_data = sr_q;
      IDX_SLAVE_ADDR: rd_data = sva_q;
      IDX_INT_TIMING: rd_data = interrupt_timing_reg_q;
      IDX_PORT: rd_data[PORT_CLK_BIT] = port_q;
      IDX_STATUS: begin
        rd_data[STAT_DONE_BIT] = done_q;
        rd_data[STAT_BUSY_BIT] = busy;
      end
      default: rd_data = 8'h00;
    endcase
  end

  // Configuration register writes
  always_comb begin
    clk_sel_d = clk_sel_q;
    mode_d = mode_q;
    bctl_d = bctl_q;
    interrupt_timing_reg_d = interrupt_timing_reg_q;
    sva_d = sva_q;
    port_d = port_q;
    if (wr_en) begin
      unique case (reg_idx)
        IDX_CLK_SEL: clk_sel_d = wr_data;
        IDX_MODE: begin
          mode_d = wr_data;
          mode_d[MODE_MATCH_BIT] = 1'b0;
        end
        IDX_BUS_CTL: begin
          bctl_d = wr_data;
          bctl_d[BCTL_SET_BIT] = 1'b0; // R20
          bctl_d[BCTL_CLR_BIT] = 1'b0; // R20
        end
        IDX_SLAVE_ADDR: sva_d = wr_data;
        IDX_INT_TIMING: interrupt_timing_reg_d = wr_data;
        IDX_PORT: port_d = wr_data[PORT_CLK_BIT];
        default: begin
        end
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_sel_q <= CLK_SEL_RST; // R17
      mode_q <= MODE_RST;
      bctl_q <= BCTL_RST;
      interrupt_timing_reg_q <= INT_TIMING_RST;
      sva_q <= SLAVE_ADDR_RST;
      port_q <= PORT_RST;
    end else begin
      clk_sel_q <= clk_sel_d;
      mode_q <= mode_d;
      bctl_q <= bctl_d;
      interrupt_timing_reg_q <= interrupt_timing_reg_d;
      sva_q <= sva_d;
      port_q <= port_d;
    end
  end

  // Shifter, done flag and output latch next state
  always_comb begin
    sr_d = sr_q;
    done_d = done_q;
    state_d = state_q;
    cnt_d = cnt_q;
    sck_lvl_d = sck_lvl_q;
    out_latch_d = out_latch_q;
    if (wr_en) begin
      unique case (reg_idx)
        IDX_BUS_CTL: begin
          if (enable && wr_data[BCTL_SET_BIT]) begin
            out_latch_d = 1'b1; // R20
          end else if (enable && wr_data[BCTL_CLR_BIT]) begin
            out_latch_d = 1'b0; // R20
          end
        end
        IDX_SHIFT: begin
          if (!busy) begin
            sr_d = wr_data;
          end
        end
        IDX_STATUS: begin
          if (wr_data[STAT_DONE_BIT]) begin
            done_d = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    unique case (state_q)
      ST_IDLE: begin
        sck_lvl_d = 1'b1; // R14
        if (start) begin
          cnt_d = 3'h0; // R24
          state_d = ST_WAIT_FALL;
        end
      end
      ST_WAIT_FALL: begin
        if (fall_ev) begin
          sck_lvl_d = 1'b0;
          out_latch_d = sr_q[7]; // R2 R3
          state_d = ST_WAIT_RISE;
        end
      end
      ST_WAIT_RISE: begin
        if (rise_ev) begin
          sck_lvl_d = 1'b1;
          sr_d = {sr_q[6:0], line_in}; // R4 R11
          cnt_d = cnt_q + 3'h1; // R1 R24
          if (cnt_q == BIT_CNT_LAST) begin
            done_d = 1'b1; // R5
            state_d = ST_IDLE; // R5
          end else begin
            state_d = ST_WAIT_FALL;
          end
        end
      end
    endcase
    if (!mode_d[MODE_EN_BIT]) begin
      state_d = ST_IDLE;
      sck_lvl_d = 1'b1;
    end
  end

  // Shifter state registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sr_q <= SHIFT_RST;
      done_q <= 1'b0;
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      sck_lvl_q <= 1'b1;
      out_latch_q <= 1'b1;
    end else begin
      sr_q <= sr_d;
      done_q <= done_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      sck_lvl_q <= sck_lvl_d;
      out_latch_q <= out_latch_d;
    end
  end

  // Pin drivers, open-drain pull-low only
  always_comb begin
    sck_oe_d = 1'b0;
    a_oe_d = 1'b0;
    b_oe_d = 1'b0;
    if (enable && two_wire) begin
      if (internal_clk) begin
        sck_oe_d = busy ? !sck_lvl_q : !port_q; // R14
      end
      a_oe_d = use_line_a && !out_latch_q; // R3 R6
      b_oe_d = !use_line_a && !out_latch_q; // R3 R6
    end
  end


  // Pin register stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_prev_q <= 1'b1;
      sck_oe_q <= 1'b0;
      a_oe_q <= 1'b0;
      b_oe_q <= 1'b0;
      sck_out_q <= 1'b0;
      a_out_q <= 1'b0;
      b_out_q <= 1'b0;
    end else begin
      sck_prev_q <= serial_clock_pin_in;
      sck_oe_q <= sck_oe_d;
      a_oe_q <= a_oe_d;
      b_oe_q <= b_oe_d;
      sck_out_q <= 1'b0; // R6
      a_out_q <= 1'b0; // R6
      b_out_q <= 1'b0; // R6
    end
  end
endmodule
`default_nettype wire

/* File: include/tws_pkg.sv */
// Constants, register map and types of the two-wire serial channel
// Overview of operation
// R1 - One byte per transfer, one bit per serial clock period, both sides synchronous.
// R2 - Shift register presents its next output bit on each serial clock falling edge.
// R3 - Output bits go through the output latch onto the selected line, MSB first.
// R4 - Level on the selected data line is captured on each serial clock rising edge.
// R5 - After eight bits the shifter halts itself and sets the transfer done flag.
// R6 - Data line is open-drain, pull low only; system supplies the pull-up.
// R7 - Software loads all ones before receiving so the line stays released.
// R8 - Software uses line set and clear triggers only while no transfer runs.
// R9 - Shift register write starts a transfer only if enabled and clock idle high.
// R10 - Enabling the channel after the byte was written starts no transfer.
// R11 - While sending, the real line level is shifted back into the register.
// R12 - Software flags an error when register content differs before and after.
// R13 - Read-only match flag shows slave address register equals shift register.
// R14 - Idle internal clock output sits high and follows the clock pin port latch.
// R15 - Software sets clock output mode first, then moves the port latch.
// R16 - Low nibble of clock select picks main clock over 4 to 512; others prohibited.
// R17 - Clock select register resets to 88 hex.
// R18 - Software stops transfers before changing the clock select register.
// R19 - Software keeps the low four bits of interrupt timing register at zero.
// R20 - Line set trigger drives latch high, clear trigger low; both self-clear.
// R21 - Software keeps the wake-up select bit at zero in two-wire mode.
// R22 - Clock source: upper bit 0 external pin, 10 timer output, 11 divider.
// R23 - Match flag reads zero while the channel is disabled.
// R24 - Three-bit counter cleared at start ends the byte after eight clock periods.
`default_nettype none
package tws_pkg;
  localparam int ADDR_W = 20;
  localparam int IDX_W = 18;
  localparam logic [IDX_W-1:0] IDX_CLK_SEL = 18'h0FF43;
  localparam logic [IDX_W-1:0] IDX_MODE = 18'h0FF60;
  localparam logic [IDX_W-1:0] IDX_BUS_CTL = 18'h0FF61;
  localparam logic [IDX_W-1:0] IDX_SHIFT = 18'h0FF62;
  localparam logic [IDX_W-1:0] IDX_SLAVE_ADDR = 18'h0FF63;
  localparam logic [IDX_W-1:0] IDX_INT_TIMING = 18'h0FF64;
  localparam logic [IDX_W-1:0] IDX_PORT = 18'h0FF65;
  localparam logic [IDX_W-1:0] IDX_STATUS = 18'h0FF66;
  localparam int MODE_EN_BIT = 7;
  localparam int MODE_MATCH_BIT = 6;
  localparam int MODE_SEL_HI = 4;
  localparam int MODE_SEL_MID = 3;
  localparam int MODE_SEL_LO = 2;
  localparam int MODE_SRC_HI = 1;
  localparam int MODE_SRC_LO = 0;
  localparam int BCTL_SET_BIT = 0;
  localparam int BCTL_CLR_BIT = 1;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int PORT_CLK_BIT = 0;
  localparam int CLKSEL_CH0_LSB = 0;
  localparam int CLKSEL_CH0_W = 4;
  localparam logic [7:0] CLK_SEL_RST = 8'h88;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] BCTL_RST = 8'h00;
  localparam logic [7:0] INT_TIMING_RST = 8'h00;
  localparam logic [7:0] SLAVE_ADDR_RST = 8'h00;
  localparam logic [7:0] SHIFT_RST = 8'hFF;
  localparam logic PORT_RST = 1'b1;
  localparam logic [3:0] DIV_CODE_MIN = 4'h8;
  localparam logic [3:0] DIV_CODE_OFS = 4'h7;
  localparam int DIV_CNT_W = 9;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam logic [1:0] MODE_TWO_WIRE = 2'h3;
  localparam logic [1:0] SRC_TIMER = 2'h2;
  localparam logic [1:0] SRC_DIVIDER = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_FALL, ST_WAIT_RISE} tws_state_t;
endpackage
`default_nettype wire

/* File: rtl/tws_clkdiv.sv */
// Serial clock divider producing half-period enable pulses
`default_nettype none
module tws_clkdiv #(
  parameter int CNT_W = tws_pkg::DIV_CNT_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic [3:0] code,
  output logic tick
);
  import tws_pkg::*;
  logic [CNT_W-1:0] cnt_q, cnt_d, half_m1;
  logic tick_q, tick_d;
  logic [3:0] sh;
  logic legal;
  assign tick = tick_q;
  always_comb begin
    legal = code >= DIV_CODE_MIN; // R16
    sh = code - DIV_CODE_OFS;
    half_m1 = (CNT_W'(1) << sh) - CNT_W'(1); // R16
    cnt_d = cnt_q + CNT_W'(1);
    tick_d = 1'b0;
    if (!run || !legal) begin
      cnt_d = '0;
    end else if (cnt_q >= half_m1) begin
      cnt_d = '0;
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/tws_ahb.sv */
// AHB-Lite slave front end for the serial channel registers
`default_nettype none
module tws_ahb (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [tws_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic wr_en,
  output logic [tws_pkg::IDX_W-1:0] reg_idx,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);
  import tws_pkg::*;
  logic wr_q, wr_d, rd_q, rd_d, rdy_q, rdy_d;
  logic [IDX_W-1:0] idx_q, idx_d;
  logic [31:0] rdata_q, rdata_d;
  logic take;
  assign hreadyout = rdy_q;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign wr_en = wr_q;
  assign reg_idx = idx_q;
  assign wr_data = hwdata[7:0];
  always_comb begin
    take = hsel && hready && htrans[1] && (hsize == 3'h2 || hsize != 3'h2);
    wr_d = 1'b0;
    rd_d = 1'b0;
    rdy_d = 1'b1;
    idx_d = idx_q;
    rdata_d = rdata_q;
    if (rd_q) begin
      rdata_d = {24'h000000, rd_data};
    end
    if (take) begin
      idx_d = haddr[ADDR_W-1:2];
      wr_d = hwrite;
      rd_d = !hwrite;
      rdy_d = hwrite;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rdy_q <= 1'b1;
      idx_q <= '0;
      rdata_q <= 32'h00000000;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      rdy_q <= rdy_d;
      idx_q <= idx_d;
      rdata_q <= rdata_d;
    end
  end
endmodule
`default_nettype wire

/* File: sim/tws_checker.sv */
// Assertion checker for the two-wire serial channel
`default_nettype none
module tws_checker import tws_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [tws_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe,
  input wire logic bus_line_a_out,
  input wire logic bus_line_a_oe,
  input wire logic bus_line_b_out
);
  logic rq, rise, wr_q, wr_d, ck_q, ck_d, en_q, en_d, so_q;
  logic [17:0] ix_q, ix_d;
  logic [3:0] fc_q, fc_d, fa_q, fa_d, wa_q, wa_d;
  assign rq = hsel && hready && htrans[1];
  assign rise = serial_clock_pin_oe && !so_q;
  always_comb begin
    wr_d = rq && hwrite;
    ix_d = rq ? haddr[19:2] : ix_q;
    ck_d = ck_q || (wr_q && ix_q == IDX_CLK_SEL);
    en_d = (wr_q && ix_q == IDX_MODE) ? hwdata[MODE_EN_BIT] : en_q;
    fc_d = fc_q + 4'(rise && fc_q != 4'hF);
    if (rq && hwrite && (haddr[19:2] == IDX_SHIFT || haddr[19:2] == IDX_PORT)) begin
      fc_d = 4'h0;
    end
    fa_d = rise ? 4'h0 : fa_q + 4'(fa_q != 4'hF);
    wa_d = wr_q ? 4'h0 : wa_q + 4'(wa_q != 4'hF);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_q, ck_q, en_q, so_q, ix_q} <= '0;
      {fc_q, fa_q, wa_q} <= 12'h0FF;
    end else begin
      {wr_q, ck_q, en_q, so_q, ix_q} <= {wr_d, ck_d, en_d, serial_clock_pin_oe, ix_d};
      {fc_q, fa_q, wa_q} <= {fc_d, fa_d, wa_d};
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd(logic [17:0] i);
    rq && !hwrite && haddr[19:2] == i;
  endsequence
  sequence s_ans;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rdwait; rq && !hwrite |=> s_ans; endproperty
  property p_wrzero; rq && hwrite |=> hreadyout; endproperty
  property p_resp; hresp == 1'h0 && (!hreadyout || hrdata[31:8] == 24'h0); endproperty
  property p_rst; s_rd(IDX_CLK_SEL) ##0 !ck_q |=> ##1 hrdata[7:0] == CLK_SEL_RST; endproperty
  property p_match; s_rd(IDX_MODE) ##0 !en_q |=> ##1 !hrdata[MODE_MATCH_BIT]; endproperty
  property p_trig; s_rd(IDX_BUS_CTL) |=> ##1 hrdata[1:0] == 2'h0; endproperty
  property p_od; !serial_clock_pin_out && !bus_line_a_out && !bus_line_b_out; endproperty
  property p_cnt; fc_q <= 4'h8; endproperty
  property p_half; $changed(serial_clock_pin_oe) |=> $stable(serial_clock_pin_oe); endproperty
  property p_shift; $changed(bus_line_a_oe) |-> fa_q <= 4'h3 || rise || wa_q <= 4'h4; endproperty
  a_rdwait: assert property (p_rdwait) else $error("read wait state wrong");
  a_wrzero: assert property (p_wrzero) else $error("write not zero wait");
  a_resp: assert property (p_resp) else $error("response or upper data wrong");
  a_rst: assert property (p_rst) else $error("clock select reset value wrong");
  a_match: assert property (p_match) else $error("match flag set while disabled");
  a_trig: assert property (p_trig) else $error("trigger bits not self clearing");
  a_od: assert property (p_od) else $error("pin driven high");
  a_cnt: assert property (p_cnt) else $error("more than eight clocks per byte");
  a_half: assert property (p_half) else $error("serial clock phase too short");
  a_shift: assert property (p_shift) else $error("data moved off clock fall");
endmodule
bind tws_top tws_checker tws_checker_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hwdata, .hreadyout, .hresp, .hrdata, .serial_clock_pin_out, .serial_clock_pin_oe,
  .bus_line_a_out, .bus_line_a_oe, .bus_line_b_out);
`default_nettype wire

/* File: sim/tws_peer.sv */
// Serial peer model on the clock and data lines
`default_nettype none
module tws_peer (
  input wire logic sck,
  input wire logic sda,
  input wire logic [7:0] tx,
  output logic oe,
  output logic [7:0] rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] n = 3'h0;
  initial oe = 1'h0;
  initial rx = 8'h0;
  always @(negedge sck) oe <= ~tx[3'h7 - n];
  always @(posedge sck) begin
    rx <= {rx[6:0], sda};
    n <= n + 3'h1;
    if (n == 3'h7) oe <= 1'h0;
  end
endmodule
`default_nettype wire

/* File: sim/tws_top_tb_top.sv */
// Self-checking bench of the two-wire serial channel
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module tws_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tws_pkg::*;
  logic hclk = 1'h0, hresetn = 1'h0, hwrite = 1'h0, tick = 1'h0, rdp = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [19:0] haddr = 20'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rv;
  logic hreadyout, hresp, sck_oe, a_oe, b_oe, p_oe, sck_w, a_w, b_w;
  logic [7:0] ptx = 8'hFF, prx, ev;
  int error_cnt = 0, cmp_count = 0, cyc = 0, seed = 32'h9509DDBA;
  logic [7:0] exq[$];
  bit mkq[$];
  assign sck_w = !sck_oe;
  assign a_w = !(a_oe || p_oe);
  assign b_w = !b_oe;
  tws_top tws_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .timer2_tick(tick), .serial_clock_pin_in(sck_w),
    .serial_clock_pin_out(), .serial_clock_pin_oe(sck_oe), .bus_line_a_in(a_w), .bus_line_a_out(),
    .bus_line_a_oe(a_oe), .bus_line_b_in(b_w), .bus_line_b_out(), .bus_line_b_oe(b_oe));
  tws_peer tws_peer_i (.sck(sck_w), .sda(a_w), .tx(ptx), .oe(p_oe), .rx(prx));
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) tick <= ~tick;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      test_done();
    end
  end
  always @(posedge hclk) begin
    if (rdp && hreadyout && mkq.pop_front()) begin
      ev = exq.pop_front();
      `CHK(hrdata, {24'h0, ev})
    end
  end
  task automatic test_done;
    $display("Comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [17:0] i, input logic [7:0] d, input bit mk);
    htrans <= 2'h2;
    haddr <= {i, 2'h0};
    hwrite <= w;
    if (!w) mkq.push_back(mk);
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    rdp <= !w;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    rv = hrdata;
    rdp <= 1'h0;
  endtask
  task automatic wr(input logic [17:0] i, input logic [7:0] d);
    bus(1'h1, i, d, 1'h0);
  endtask
  task automatic ck(input logic [17:0] i, input logic [7:0] e);
    exq.push_back(e);
    bus(1'h0, i, 8'h0, 1'h1);
  endtask
  task automatic xfer(input logic [1:0] src, input logic [3:0] code, input logic [7:0] dv, pv);
    int n;
    wr(IDX_CLK_SEL, {4'h8, code});
    wr(IDX_SLAVE_ADDR, dv);
    wr(IDX_MODE, {6'h27, src});
    ptx = pv;
    wr(IDX_STATUS, 8'h01);
    wr(IDX_SHIFT, dv);
    n = 0;
    while (sck_w && n < 600) begin
      @(posedge hclk);
      n++;
    end
    n = 0;
    while (!sck_w && n < 600) begin
      n++;
      @(posedge hclk);
    end
    if (src == 2'h3) `CHK(n, 2 ** (code - 7))
    n = 0;
    rv = 32'h0;
    while (rv[STAT_DONE_BIT] !== 1'h1 && n < 5000) begin
      bus(1'h0, IDX_STATUS, 8'h0, 1'h0);
      n++;
    end
    `CHK(rv[STAT_DONE_BIT], 1'h1)
    ck(IDX_SHIFT, dv & pv);
    `CHK(prx, dv & pv)
    ck(IDX_MODE, {1'h1, (dv & pv) == dv, 4'h7, src});
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    ck(IDX_CLK_SEL, CLK_SEL_RST);
    ck(IDX_SHIFT, SHIFT_RST);
    ck(IDX_MODE, MODE_RST);
    ck(18'h00123, 8'h00);
    wr(IDX_INT_TIMING, 8'h50);
    ck(IDX_INT_TIMING, 8'h50);
    wr(IDX_SHIFT, 8'h5A);
    wr(IDX_MODE, 8'h9F);
    repeat (40) @(posedge hclk);
    ck(IDX_STATUS, 8'h00);
    for (int c = 8; c < 16; c++) xfer(2'h3, 4'(c), 8'($random(seed)), 8'hFF);
    xfer(2'h3, 4'h8, 8'($random(seed)), 8'($random(seed)));
    xfer(2'h3, 4'h9, 8'hFF, 8'h3C);
    xfer(2'h2, 4'h8, 8'hA5, 8'hFF);
    wr(IDX_BUS_CTL, 8'h02);
    repeat (4) @(posedge hclk);
    `CHK(a_w, 1'h0)
    ck(IDX_BUS_CTL, 8'h00);
    wr(IDX_BUS_CTL, 8'h01);
    repeat (4) @(posedge hclk);
    `CHK(a_w, 1'h1)
    wr(IDX_MODE, 8'h9B);
    wr(IDX_BUS_CTL, 8'h02);
    repeat (4) @(posedge hclk);
    `CHK(b_w, 1'h0)
    wr(IDX_BUS_CTL, 8'h01);
    repeat (4) @(posedge hclk);
    `CHK(b_w, 1'h1)
    wr(IDX_MODE, 8'h9F);
    wr(IDX_PORT, 8'h00);
    repeat (4) @(posedge hclk);
    `CHK(sck_w, 1'h0)
    wr(IDX_PORT, 8'h01);
    repeat (4) @(posedge hclk);
    `CHK(sck_w, 1'h1)
    wr(IDX_MODE, 8'h1F);
    ck(IDX_MODE, 8'h1F);
    test_done();
  end
endmodule
`default_nettype wire
